// [hdl/tfg_pkg.sv]
// Constants shared by the transceiver configuration bank
package tfg_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int unsigned DATA_W    = 14;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned FRAME_LEN = DATA_W + ADDR_W;
  localparam int unsigned CNT_W     = 5;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [3:0] ADDR_FILTER_PROG = 4'h7;
  localparam logic [3:0] ADDR_MODE_MON    = 4'h8;
  localparam logic [3:0] ADDR_GAIN_SRC    = 4'h9;
  localparam logic [3:0] ADDR_TX_GAIN     = 4'hc;
  localparam logic [3:0] ADDR_RX_BIAS     = 4'hf;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [13:0] RST_FILTER_PROG = 14'h0000;
  localparam logic [13:0] RST_MODE_MON    = 14'h0000;
  localparam logic [13:0] RST_GAIN_SRC    = 14'h0000;
  localparam logic [13:0] RST_TX_GAIN     = 14'h0000;
  localparam logic [13:0] RST_RX_BIAS     = 14'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned HP_CORNER_LSB   = 12;
  localparam int unsigned TX_FINE_LSB     = 3;
  localparam int unsigned TX_COARSE_LSB   = 0;
  localparam int unsigned MON_SEL_LSB     = 8;
  localparam int unsigned MON_GATE_BIT    = 10;
  localparam int unsigned GAIN_SRC_BIT    = 10;
  localparam int unsigned TX_GAIN_LSB     = 0;
  localparam int unsigned RX_CM_LSB       = 10;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [2:0] TX_FINE_MAX      = 3'h5;
  localparam logic [1:0] MON_SEL_SIGNAL_STRENGTH_MONITOR     = 2'h0;
  localparam logic [1:0] MON_SEL_TEMP     = 2'h1;
  localparam logic [1:0] MON_SEL_PDET     = 2'h2;
  localparam logic [5:0] GAIN_FINE_FLOOR  = 6'h30;
  localparam logic [5:0] GAIN_MAX_CODE    = 6'h3f;
  localparam logic [5:0] GAIN_COARSE_TOP  = 6'h2f;
  localparam logic [6:0] GAIN_COARSE_BASE = 7'h10;

  // Highpass corner presented to the analog side
  typedef enum logic [1:0] {
    TFG_HP_100HZ = 2'h0,
    TFG_HP_4KHZ  = 2'h1,
    TFG_HP_30KHZ = 2'h2,
    TFG_HP_600KHZ = 2'h3
  } tfg_hp_corner_t;

  // Operating mode, Gray coded along shutdown, receive, transmit
  typedef enum logic [1:0] {
    TFG_MODE_OFF = 2'b00,
    TFG_MODE_RX  = 2'b01,
    TFG_MODE_TX  = 2'b11
  } tfg_mode_t;

endpackage : tfg_pkg

// [hdl/tfg_serial_rx.sv]
// Three-wire serial write receiver for the configuration bank
`timescale 1ns/1ps
`default_nettype none

module tfg_serial_rx
  import tfg_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              din_i,
  output logic                   wr_valid_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]      wr_data_o
);

  logic [FRAME_LEN-1:0] shift_reg;
  logic [CNT_W-1:0]     bit_cnt_reg;
  logic                 sclk_prev_reg;
  logic                 cs_n_prev_reg;

  wire sclk_rise   = sclk_i & ~sclk_prev_reg;
  wire frame_end   = cs_n_i & ~cs_n_prev_reg;
  wire frame_whole = (bit_cnt_reg == CNT_W'(FRAME_LEN));
  wire cnt_full    = (bit_cnt_reg == {CNT_W{1'b1}});

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_i;
      cs_n_prev_reg <= cs_n_i;
    end
  end

  // Bits are taken on rising serial clock while select is low
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (cs_n_i) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg   <= {shift_reg[FRAME_LEN-2:0], din_i};
      bit_cnt_reg <= cnt_full ? bit_cnt_reg : bit_cnt_reg + CNT_W'(1);
    end
  end

  // Frames of the wrong length are dropped, so a glitch cannot corrupt a field
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_valid_o <= 1'b0;
      wr_addr_o  <= '0;
      wr_data_o  <= '0;
    end else begin
      wr_valid_o <= frame_end & frame_whole;
      if (frame_end & frame_whole) begin
        wr_addr_o <= shift_reg[ADDR_W-1:0];
        wr_data_o <= shift_reg[FRAME_LEN-1:ADDR_W];
      end
    end
  end

endmodule : tfg_serial_rx

`default_nettype wire

// [hdl/tfg_config_top.sv]
// Configuration register bank and decode for the transceiver receive and transmit chains
`timescale 1ns/1ps
`default_nettype none

module tfg_config_top
  import tfg_pkg::*;
#(
  parameter int unsigned SYNC_STAGES   = 2,
  parameter logic        MON_GATE_WHEN = 1'b0
)
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rx_highpass_select_i,
  input  wire logic        rx_tx_select_i,
  input  wire logic        shutdown_n_i,
  input  wire logic [5:0]  parallel_gain_pins_i,
  input  wire logic        serial_cs_n_i,
  input  wire logic        serial_clk_i,
  input  wire logic        serial_din_i,
  output logic [1:0]       rx_hp_corner_o,
  output logic [1:0]       rx_cm_level_o,
  output logic [1:0]       monitor_sel_o,
  output logic             monitor_enable_o,
  output logic             rx_enable_o,
  output logic             tx_enable_o,
  output logic [1:0]       tx_lpf_coarse_o,
  output logic [2:0]       tx_lpf_fine_o,
  output logic             tx_lpf_fine_valid_o,
  output logic             tx_gain_serial_o,
  output logic [5:0]       tx_gain_code_o,
  output logic [6:0]       tx_gain_atten_o
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ****************************************
  // Functions
  // ****************************************
  // Attenuation below maximum in half-dB units
  function automatic logic [6:0] gain_atten(input logic [5:0] code);
    logic [5:0] below;
    below = 6'h00;
    if (code >= GAIN_FINE_FLOOR) begin
      gain_atten = {1'b0, GAIN_MAX_CODE - code};
    end else begin
      below = GAIN_COARSE_TOP - code;
      gain_atten = {1'b0, GAIN_COARSE_BASE[5:0] + {below[5:1], 1'b0}};
    end
  endfunction : gain_atten

  function automatic tfg_hp_corner_t hp_corner(input logic pin, input logic [1:0] field);
    if (pin) begin
      hp_corner = TFG_HP_600KHZ;
    end else if (field[0]) begin
      hp_corner = TFG_HP_4KHZ;
    end else if (field[1]) begin
      hp_corner = TFG_HP_30KHZ;
    end else begin
      hp_corner = TFG_HP_100HZ;
    end
  endfunction : hp_corner

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned PW = 12;

  logic [PW-1:0] sync_chain_reg [SYNC_STAGES];
  wire  [PW-1:0] pins_raw = {serial_din_i, serial_clk_i, serial_cs_n_i, parallel_gain_pins_i,
                             shutdown_n_i, rx_tx_select_i, rx_highpass_select_i};
  wire  [PW-1:0] pins_s   = sync_chain_reg[SYNC_STAGES-1];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_chain_reg[i] <= 12'h200;
      end
    end else begin
      sync_chain_reg[0] <= pins_raw;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_chain_reg[i] <= sync_chain_reg[i-1];
      end
    end
  end

  wire       hp_pin_s    = pins_s[0];
  wire       rx_tx_select_pin_s  = pins_s[1];
  wire       shutdown_n_n_s    = pins_s[2];
  wire [5:0] par_gain_s  = pins_s[8:3];
  wire       cs_n_s      = pins_s[9];
  wire       sclk_s      = pins_s[10];
  wire       din_s       = pins_s[11];

  // ****************************************
  // Serial write port
  // ****************************************
  logic              wr_valid;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  tfg_serial_rx u_serial_rx (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cs_n_i     (cs_n_s),
    .sclk_i     (sclk_s),
    .din_i      (din_s),
    .wr_valid_o (wr_valid),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data)
  );

  // ****************************************
  // Register file
  // ****************************************
  logic [13:0] filter_programming_reg;
  logic [13:0] mode_and_monitor_config_reg;
  logic [13:0] tx_gain_source_config_reg;
  logic [13:0] tx_gain_setting_reg;
  logic [13:0] rx_output_bias_config_reg;

  // Writes to other addresses belong to registers outside this bank and are ignored
  wire wr_filter = wr_valid & (wr_addr == ADDR_FILTER_PROG);
  wire wr_mode   = wr_valid & (wr_addr == ADDR_MODE_MON);
  wire wr_src    = wr_valid & (wr_addr == ADDR_GAIN_SRC);
  wire wr_gain   = wr_valid & (wr_addr == ADDR_TX_GAIN);
  wire wr_bias   = wr_valid & (wr_addr == ADDR_RX_BIAS);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      filter_programming_reg      <= RST_FILTER_PROG;
      mode_and_monitor_config_reg <= RST_MODE_MON;
      tx_gain_source_config_reg   <= RST_GAIN_SRC;
      tx_gain_setting_reg         <= RST_TX_GAIN;
      rx_output_bias_config_reg   <= RST_RX_BIAS;
    end else begin
      if (wr_filter) filter_programming_reg      <= wr_data;
      if (wr_mode)   mode_and_monitor_config_reg <= wr_data;
      if (wr_src)    tx_gain_source_config_reg   <= wr_data;
      if (wr_gain)   tx_gain_setting_reg         <= wr_data;
      if (wr_bias)   rx_output_bias_config_reg   <= wr_data;
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  wire [1:0] hp_field     = filter_programming_reg[HP_CORNER_LSB +: 2];
  wire [2:0] tx_fine_fld  = filter_programming_reg[TX_FINE_LSB +: 3];
  wire [1:0] tx_coarse_fld = mode_and_monitor_config_reg[TX_COARSE_LSB +: 2];
  wire [1:0] mon_sel_fld  = mode_and_monitor_config_reg[MON_SEL_LSB +: 2];
  wire       mon_gate_bit = mode_and_monitor_config_reg[MON_GATE_BIT];
  wire       gain_serial  = tx_gain_source_config_reg[GAIN_SRC_BIT];
  wire [5:0] ser_gain_fld = tx_gain_setting_reg[TX_GAIN_LSB +: 6];
  wire [1:0] rx_cm_fld    = rx_output_bias_config_reg[RX_CM_LSB +: 2];

  // ****************************************
  // Operating mode
  // ****************************************
  tfg_mode_t mode_next;

  always_comb begin
    case ({shutdown_n_n_s, rx_tx_select_pin_s})
      2'b11:   mode_next = TFG_MODE_TX;
      2'b10:   mode_next = TFG_MODE_RX;
      default: mode_next = TFG_MODE_OFF;
    endcase
  end

  // ****************************************
  // Monitor routing
  // ****************************************
  // Gating polarity is a parameter because its sense is not settled
  wire mon_gated   = (mon_gate_bit == MON_GATE_WHEN);
  wire mon_hp_ok   = ~mon_gated | hp_pin_s;
  wire mon_src_ok  = (mon_sel_fld == MON_SEL_SIGNAL_STRENGTH_MONITOR) ? (mode_next == TFG_MODE_RX) :
                     (mon_sel_fld == MON_SEL_TEMP) | (mon_sel_fld == MON_SEL_PDET);
  wire mon_en_next = mon_hp_ok & mon_src_ok;

  // ****************************************
  // Transmit gain and filter decode
  // ****************************************
  wire [5:0] gain_code_next = gain_serial ? ser_gain_fld : par_gain_s;
  wire       fine_ok_next   = (tx_fine_fld <= TX_FINE_MAX);

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_hp_corner_o      <= TFG_HP_100HZ;
      rx_cm_level_o       <= 2'h0;
      monitor_sel_o       <= MON_SEL_SIGNAL_STRENGTH_MONITOR;
      monitor_enable_o    <= 1'b0;
      rx_enable_o         <= 1'b0;
      tx_enable_o         <= 1'b0;
      tx_lpf_coarse_o     <= 2'h0;
      tx_lpf_fine_o       <= 3'h0;
      tx_lpf_fine_valid_o <= 1'b0;
      tx_gain_serial_o    <= 1'b0;
      tx_gain_code_o      <= 6'h00;
      tx_gain_atten_o     <= 7'h00;
    end else begin
      rx_hp_corner_o      <= hp_corner(hp_pin_s, hp_field);
      rx_cm_level_o       <= rx_cm_fld;
      monitor_sel_o       <= mon_sel_fld;
      monitor_enable_o    <= mon_en_next;
      rx_enable_o         <= (mode_next == TFG_MODE_RX);
      tx_enable_o         <= (mode_next == TFG_MODE_TX);
      tx_lpf_coarse_o     <= tx_coarse_fld;
      tx_lpf_fine_o       <= tx_fine_fld;
      tx_lpf_fine_valid_o <= fine_ok_next;
      tx_gain_serial_o    <= gain_serial;
      tx_gain_code_o      <= gain_code_next;
      tx_gain_atten_o     <= gain_atten(gain_code_next);
    end
  end

endmodule : tfg_config_top

`default_nettype wire

// [tb/tfg_ctrl_model.sv]
// Baseband controller model driving the three-wire serial write port
`timescale 1ns/1ps
`default_nettype none

module tfg_ctrl_model (
  input  wire logic core_clk_i,
  output var logic  cs_n_o,
  output var logic  sclk_o,
  output var logic  din_o
);
  // ****************************************
  // Frame driver
  // ****************************************
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  // Sends the top nbits of a frame; levels held four cycles, three above the one-cycle minimum
  task automatic send(input logic [17:0] frame, input int nbits);
    cs_n_o = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      din_o = frame[17-k];
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge core_clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge core_clk_i);
    cs_n_o = 1'b1;
    // Released data line must not keep showing the last bit
    din_o = ~din_o;
    repeat (4) @(negedge core_clk_i);
  endtask : send
endmodule : tfg_ctrl_model
`default_nettype wire

// [tb/tfg_config_top_props.sv]
// Port assertions for the transceiver configuration bank
`timescale 1ns/1ps
`default_nettype none

module tfg_config_top_props
  import tfg_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
)
(
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       rx_highpass_select_i,
  input wire logic       rx_tx_select_i,
  input wire logic       shutdown_n_i,
  input wire logic [5:0] parallel_gain_pins_i,
  input wire logic [1:0] rx_hp_corner_o,
  input wire logic [1:0] monitor_sel_o,
  input wire logic       monitor_enable_o,
  input wire logic       rx_enable_o,
  input wire logic       tx_enable_o,
  input wire logic [2:0] tx_lpf_fine_o,
  input wire logic       tx_lpf_fine_valid_o,
  input wire logic       tx_gain_serial_o,
  input wire logic [5:0] tx_gain_code_o,
  input wire logic [6:0] tx_gain_atten_o
);
  // ****************************************
  // Checks
  // ****************************************
  localparam int unsigned LAT = SYNC_STAGES + 1;
  // Pin history from before release is meaningless, so checks wait out the pipeline
  logic [3:0] settle_reg;
  logic       ok;
  assign ok = settle_reg > 4'(LAT);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) settle_reg <= 4'h0;
    else if (!ok) settle_reg <= settle_reg + 4'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_tx_enable_pins:
    assert property (ok |-> tx_enable_o == ($past(shutdown_n_i, LAT) && $past(rx_tx_select_i, LAT)))
    else $error("tx enable mismatch");
  a_rx_enable_pins:
    assert property (ok |-> rx_enable_o == ($past(shutdown_n_i, LAT) && !$past(rx_tx_select_i, LAT)))
    else $error("rx enable mismatch");
  a_highpass_force:
    assert property (ok && $past(rx_highpass_select_i, LAT) |-> rx_hp_corner_o == 2'h3)
    else $error("highpass pin not forcing corner");
  a_fine_valid_code:
    assert property (ok |-> tx_lpf_fine_valid_o == (tx_lpf_fine_o <= TX_FINE_MAX))
    else $error("fine valid mismatch");
  a_gain_atten_map:
    assert property (ok |-> tx_gain_atten_o == ((tx_gain_code_o >= GAIN_FINE_FLOOR) ? 7'(GAIN_MAX_CODE -
      tx_gain_code_o) : GAIN_COARSE_BASE + 7'((GAIN_COARSE_TOP - tx_gain_code_o) & 6'h3e)))
    else $error("gain attenuation mismatch");
  a_gain_from_pins:
    assert property (ok && !tx_gain_serial_o && !$past(tx_gain_serial_o) |->
      tx_gain_code_o == $past(parallel_gain_pins_i, LAT))
    else $error("parallel gain not followed");
  a_monitor_tx_off:
    assert property (ok && monitor_sel_o == MON_SEL_SIGNAL_STRENGTH_MONITOR && !rx_enable_o |-> !monitor_enable_o)
    else $error("strength monitor on outside receive");
  a_monitor_none_off:
    assert property (monitor_sel_o == 2'h3 |-> !monitor_enable_o)
    else $error("monitor on with no source");
endmodule : tfg_config_top_props

bind tfg_config_top tfg_config_top_props #(.SYNC_STAGES(SYNC_STAGES)) props_u (.*);
`default_nettype wire

// [tb/tfg_config_top_test.sv]
// Self-checking bench for the transceiver configuration bank
`timescale 1ns/1ps
`default_nettype none

module tfg_config_top_test
  import tfg_pkg::*;
;
  typedef struct packed {
    logic [2:0] pins;
    logic [5:0] gain;
    logic [1:0] ena;
    logic [1:0] corner;
    logic [6:0] atten;
  } tfg_row_t;

  // ****************************************
  // Stimulus table: highpass, mode, shutdown_n, gain pins; tx, rx, corner, atten
  // ****************************************
  tfg_row_t rows [6] = '{
    {3'b001, 6'h3f, 2'b01, 2'h0, 7'h00},
    {3'b101, 6'h30, 2'b01, 2'h3, 7'h0f},
    {3'b011, 6'h2f, 2'b10, 2'h0, 7'h10},
    {3'b111, 6'h2e, 2'b10, 2'h3, 7'h10},
    {3'b010, 6'h01, 2'b00, 2'h0, 7'h3e},
    {3'b000, 6'h00, 2'b00, 2'h0, 7'h3e}};
  logic       core_clk;
  logic       sys_rst;
  logic [2:0] pins;
  logic [5:0] gpins;
  logic [2:0] k;
  logic       cs_n;
  logic       sclk;
  logic       din;
  logic [1:0] corner;
  logic [1:0] cm;
  logic [1:0] msel;
  logic [1:0] coarse;
  logic [2:0] fine;
  logic       men;
  logic       rxe;
  logic       txe;
  logic       fok;
  logic       gser;
  logic [5:0] gcode;
  logic [6:0] gatt;
  int         err_total;
  int         num_checks;

  tfg_ctrl_model ctrl_u (.core_clk_i(core_clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  tfg_config_top dut_u (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .rx_highpass_select_i(pins[2]),
    .rx_tx_select_i(pins[1]), .shutdown_n_i(pins[0]), .parallel_gain_pins_i(gpins), .serial_cs_n_i(cs_n),
    .serial_clk_i(sclk), .serial_din_i(din), .rx_hp_corner_o(corner), .rx_cm_level_o(cm),
    .monitor_sel_o(msel), .monitor_enable_o(men), .rx_enable_o(rxe), .tx_enable_o(txe),
    .tx_lpf_coarse_o(coarse), .tx_lpf_fine_o(fine), .tx_lpf_fine_valid_o(fok),
    .tx_gain_serial_o(gser), .tx_gain_code_o(gcode), .tx_gain_atten_o(gatt));

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] addr, input logic [13:0] data, input int nbits);
    ctrl_u.send({data, addr}, nbits);
    repeat (8) @(negedge core_clk);
  endtask : wr

  task automatic settle();
    repeat (5) @(negedge core_clk);
  endtask : settle

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    end_sim();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    pins = 3'b101;
    gpins = 6'h3f;
    repeat (20) @(negedge core_clk);
    chk(7'({rxe, txe, corner, gcode == 6'h00}), 7'h01);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      {pins, gpins} = {rows[i].pins, rows[i].gain};
      settle();
      chk(7'({txe, rxe}), 7'(rows[i].ena));
      chk(7'(corner), 7'(rows[i].corner));
      chk(7'(gcode), 7'(rows[i].gain));
      chk(gatt, rows[i].atten);
    end
    pins = 3'b001;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(ADDR_FILTER_PROG, {k[1:0], 6'h00, k, 3'h0}, 18);
      wr(ADDR_MODE_MON, {3'h0, k[2], k[1:0], 6'h00, k[1:0]}, 18);
      chk(7'(corner), 7'((k[1:0] == 2'h2) ? 2'h2 : {1'b0, k[0]}));
      chk(7'({fok, fine}), 7'({k <= 3'h5, k}));
      chk(7'({msel, coarse}), 7'({k[1:0], k[1:0]}));
      chk(7'(men), 7'(k[2] && k[1:0] != 2'h3));
    end
    wr(ADDR_MODE_MON, 14'h0400, 18);
    chk(7'(men), 7'h01);
    pins = 3'b011;
    settle();
    chk(7'(men), 7'h00);
    wr(ADDR_MODE_MON, 14'h0100, 18);
    chk(7'(men), 7'h00);
    pins = 3'b111;
    settle();
    chk(7'(men), 7'h01);
    wr(ADDR_RX_BIAS, 14'h0c00, 18);
    chk(7'(cm), 7'h03);
    wr(4'h5, 14'h0000, 18);
    wr(ADDR_RX_BIAS, 14'h0000, 17);
    chk(7'({cm, msel, coarse}), 7'h34);
    chk(7'(fine), 7'h07);
    gpins = 6'h0f;
    wr(ADDR_TX_GAIN, 14'h002a, 18);
    chk(7'({gser, gcode}), 7'h0f);
    wr(ADDR_GAIN_SRC, 14'h0400, 18);
    chk(7'({gser, gcode}), 7'h6a);
    chk(gatt, 7'h14);
    gpins = 6'h3f;
    settle();
    chk(7'(gcode), 7'h2a);
    // Reset in mid-run must clear every field, not only the outputs
    sys_rst = 1'b1;
    settle();
    chk(7'({rxe, txe, men, gser}), 7'h00);
    sys_rst = 1'b0;
    settle();
    chk(7'({cm, msel, coarse, gser}), 7'h00);
    chk(7'({txe, gcode}), 7'h7f);
    end_sim();
  end
endmodule : tfg_config_top_test
`default_nettype wire
